// ### dll_chain.sv
/*
 Linked-list chained DMA pair: a list-following channel fetches five-word
 entries into the block-handling channel, which then moves one block
 under peripheral flow control and hands back to the list follower.
 Assumes a system bus slave that answers each request with bus_ack, and
 peripheral request lines synchronous to core_clk.
*/
// Summary of operation
// - Writing enable one starts the list-following channel.
// - Each fetch moves five words: four to block channel, one own source.
// - After its entry, list follower simply drops back to disabled.
// - Completion with partner enable set enables the named partner channel.
// - Block channel waits for peripheral requests unless memory-to-memory.
// - Count matching length clears count and sets completion status.
// - Block completion with partner enable restarts the list follower.
// - Last entry of length zero moves exactly one word, then completes.
// - Partner enable zero on completion ends the chain.
// - Non-zero peripheral select paces transfers by that peripheral's request.
// - With both selects non-zero, move only while both request.
`include "dll_consts.svh"
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Data FIFO between the read and write halves of a block transfer
module dll_fifo #(
   parameter int W = 32,
   parameter int D = `DLL_FIFO_DEPTH
) (
   input  wire logic         core_clk,
   input  wire logic         sys_rst,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem_r [D];
   logic [AW-1:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
   logic [AW:0]   cnt_r, cnt_nxt;
   logic          push, pop;

   // Honest flags straight from the occupancy count
   assign in_ready  = (cnt_r < (AW+1)'(D));
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem_r[rptr_r];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Pointer and count update
   always_comb begin
      wptr_nxt = push ? ((wptr_r == AW'(D-1)) ? '0 : wptr_r + 1'b1) : wptr_r;
      rptr_nxt = pop ? ((rptr_r == AW'(D-1)) ? '0 : rptr_r + 1'b1) : rptr_r;
      cnt_nxt  = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wptr_r <= '0;
         rptr_r <= '0;
         cnt_r  <= '0;
      end else begin
         wptr_r <= wptr_nxt;
         rptr_r <= rptr_nxt;
         cnt_r  <= cnt_nxt;
      end
   end

   // Storage needs no reset; nothing reads a slot before it is written
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_r[wptr_r] <= in_data;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////
// Chained channel pair with one system bus master port
module dll_chain #(
   parameter logic [4:0] BH_CHANNEL = `DLL_BH_CHANNEL,
   parameter logic [4:0] LF_CHANNEL = `DLL_LF_CHANNEL,
   parameter int         FIFO_DEPTH = `DLL_FIFO_DEPTH
) (
   input  wire logic             core_clk,
   input  wire logic             sys_rst,
   input  wire logic             lf_enable_wr,
   input  wire logic [31:0]      lf_first_entry,
   input  wire logic             lf_partner_enable,
   input  wire logic [4:0]       lf_partner_channel_select,
   input  wire logic             bh_done_clr,
   input  wire logic             bh_done_mask,
   output logic                  bh_done_status,
   output logic                  bh_done_irq,
   output logic                  list_end,
   output dll_pkg::dll_state_t   chain_state,
   input  wire logic [15:0]      src_periph_req,
   input  wire logic [15:0]      dst_periph_req,
   output logic                  bus_req,
   output logic                  bus_write,
   output logic [31:0]           bus_addr,
   output dll_pkg::dll_size_t    bus_size,
   output logic [31:0]           bus_wdata,
   input  wire logic             bus_ack,
   input  wire logic [31:0]      bus_rdata
);
   import dll_pkg::*;

   dll_state_t  st_r, st_nxt;
   logic [31:0] lf_src_r, lf_src_nxt, bh_src_r, bh_src_nxt;
   logic [31:0] bh_dst_r, bh_dst_nxt, bh_len_r, bh_len_nxt;
   logic [31:0] bh_cfg_r, bh_cfg_nxt, rd_cnt_r, rd_cnt_nxt;
   logic [31:0] xfer_cnt_r, xfer_cnt_nxt;
   logic [31:0] addr_r, addr_nxt, wdata_r, wdata_nxt;
   logic [2:0]  word_r, word_nxt;
   logic        busy_r, busy_nxt, we_r, we_nxt, rd_done_r, rd_done_nxt;
   logic        stat_r, stat_nxt, end_r, end_nxt;
   logic        f_ready, f_valid, f_pop, f_push;
   logic [31:0] f_data;
   logic        src_ok, dst_ok, issue_rd, issue_wr, blk_done;
   logic [3:0]  src_sel, dst_sel;
   logic [31:0] step;

   // Pacing test for one side: zero select means memory, always ready
   function automatic logic periph_ok(input logic [3:0] sel,
                                      input logic [15:0] req);
      periph_ok = (sel == 4'h0) || req[sel];
   endfunction

   assign src_sel = bh_cfg_r[`DLL_CFG_SRC_MSB:`DLL_CFG_SRC_LSB];
   assign dst_sel = bh_cfg_r[`DLL_CFG_DST_MSB:`DLL_CFG_DST_LSB];
   // Both selected peripherals must request together for any beat
   assign src_ok = periph_ok(src_sel, src_periph_req)
                 && periph_ok(dst_sel, dst_periph_req);
   assign dst_ok = src_ok;
   assign step   = 32'h1 << bh_cfg_r[`DLL_CFG_SIZE_MSB:`DLL_CFG_SIZE_LSB];

   // Reads go first; writes issue once reads are done or the FIFO is full, and then win over reads
   assign issue_wr = (st_r == DLL_BLOCK) && !busy_r && f_valid && dst_ok
                   && (rd_done_r || !f_ready);
   assign issue_rd = (st_r == DLL_BLOCK) && !busy_r && !issue_wr
                   && !rd_done_r && f_ready && src_ok;
   assign f_pop    = issue_wr;
   assign f_push   = busy_r && !we_r && bus_ack && (st_r == DLL_BLOCK);
   assign blk_done = busy_r && we_r && bus_ack
                   && (xfer_cnt_r == bh_len_r);

   dll_fifo #(.W(32), .D(FIFO_DEPTH)) u_fifo (
      .core_clk  (core_clk),
      .sys_rst   (sys_rst),
      .in_valid  (f_push),
      .in_ready  (f_ready),
      .in_data   (bus_rdata),
      .out_valid (f_valid),
      .out_ready (f_pop),
      .out_data  (f_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // Sequencer, working registers and bus beat next values
   always_comb begin
      st_nxt       = st_r;
      lf_src_nxt   = lf_src_r;
      bh_src_nxt   = bh_src_r;
      bh_dst_nxt   = bh_dst_r;
      bh_len_nxt   = bh_len_r;
      bh_cfg_nxt   = bh_cfg_r;
      rd_cnt_nxt   = rd_cnt_r;
      xfer_cnt_nxt = xfer_cnt_r;
      addr_nxt     = addr_r;
      wdata_nxt    = wdata_r;
      word_nxt     = word_r;
      busy_nxt     = busy_r;
      we_nxt       = we_r;
      rd_done_nxt  = rd_done_r;
      end_nxt      = 1'b0;
      // Hardware set wins over a clear in the same cycle
      stat_nxt     = blk_done || (stat_r && !bh_done_clr);
      case (st_r)
         DLL_IDLE: begin
            if (lf_enable_wr) begin
               lf_src_nxt = lf_first_entry;
               word_nxt   = 3'h0;
               st_nxt     = DLL_FETCH;
            end
         end
         DLL_FETCH: begin
            if (!busy_r) begin
               busy_nxt = 1'b1;
               we_nxt   = 1'b0;
               addr_nxt = lf_src_r + {27'h0, word_r, 2'b00};
            end else if (bus_ack) begin
               busy_nxt = 1'b0;
               word_nxt = word_r + 3'h1;
               // Fetched words land in working registers at once
               case (word_r)
                  3'h0: bh_src_nxt = bus_rdata;
                  3'h1: bh_dst_nxt = bus_rdata;
                  3'h2: bh_len_nxt = bus_rdata;
                  3'h3: bh_cfg_nxt = bus_rdata;
                  default: lf_src_nxt = bus_rdata;
               endcase
               if (word_r == `DLL_ENTRY_LAST) begin
                  rd_cnt_nxt   = '0;
                  xfer_cnt_nxt = '0;
                  rd_done_nxt  = 1'b0;
                  // Follower lapses to disabled; partner may start
                  st_nxt = (lf_partner_enable
                         && lf_partner_channel_select == BH_CHANNEL)
                         ? DLL_BLOCK : DLL_IDLE;
               end
            end
         end
         DLL_BLOCK: begin
            if (issue_rd) begin
               busy_nxt    = 1'b1;
               we_nxt      = 1'b0;
               addr_nxt    = bh_src_r;
               rd_done_nxt = (rd_cnt_r == bh_len_r);
               rd_cnt_nxt  = rd_cnt_r + 32'h1;
               if (src_sel == 4'h0) begin
                  bh_src_nxt = bh_src_r + step;
               end
            end else if (issue_wr) begin
               busy_nxt  = 1'b1;
               we_nxt    = 1'b1;
               addr_nxt  = bh_dst_r;
               wdata_nxt = f_data;
               if (dst_sel == 4'h0) begin
                  bh_dst_nxt = bh_dst_r + step;
               end
            end else if (busy_r && bus_ack) begin
               busy_nxt = 1'b0;
               if (we_r) begin
                  xfer_cnt_nxt = blk_done ? '0 : xfer_cnt_r + 32'h1;
               end
               if (blk_done) begin
                  if (bh_cfg_r[`DLL_CFG_PEN_BIT]
                      && bh_cfg_r[`DLL_CFG_PSEL_MSB:`DLL_CFG_PSEL_LSB]
                         == LF_CHANNEL) begin
                     word_nxt = 3'h0;
                     st_nxt   = DLL_FETCH;
                  end else begin
                     end_nxt = 1'b1;
                     st_nxt  = DLL_IDLE;
                  end
               end
            end
         end
         default: st_nxt = DLL_IDLE;
      endcase
   end

   // Register stage for the sequencer group
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_r       <= DLL_IDLE;
         lf_src_r   <= `DLL_ZERO_WORD;
         bh_src_r   <= `DLL_ZERO_WORD;
         bh_dst_r   <= `DLL_ZERO_WORD;
         bh_len_r   <= `DLL_ZERO_WORD;
         bh_cfg_r   <= `DLL_ZERO_WORD;
         rd_cnt_r   <= `DLL_ZERO_WORD;
         xfer_cnt_r <= `DLL_ZERO_WORD;
         addr_r     <= `DLL_ZERO_WORD;
         wdata_r    <= `DLL_ZERO_WORD;
         word_r     <= 3'h0;
         busy_r     <= 1'b0;
         we_r       <= 1'b0;
         rd_done_r  <= 1'b0;
         stat_r     <= 1'b0;
         end_r      <= 1'b0;
      end else begin
         st_r       <= st_nxt;
         lf_src_r   <= lf_src_nxt;
         bh_src_r   <= bh_src_nxt;
         bh_dst_r   <= bh_dst_nxt;
         bh_len_r   <= bh_len_nxt;
         bh_cfg_r   <= bh_cfg_nxt;
         rd_cnt_r   <= rd_cnt_nxt;
         xfer_cnt_r <= xfer_cnt_nxt;
         addr_r     <= addr_nxt;
         wdata_r    <= wdata_nxt;
         word_r     <= word_nxt;
         busy_r     <= busy_nxt;
         we_r       <= we_nxt;
         rd_done_r  <= rd_done_nxt;
         stat_r     <= stat_nxt;
         end_r      <= end_nxt;
      end
   end

   // Outputs; entry fetches are always whole words
   assign bus_req        = busy_r;
   assign bus_write      = we_r;
   assign bus_addr       = addr_r;
   assign bus_wdata      = wdata_r;
   assign bus_size       = (st_r == DLL_BLOCK)
      ? dll_size_t'(bh_cfg_r[`DLL_CFG_SIZE_MSB:`DLL_CFG_SIZE_LSB]) : DLL_WORD;
   assign bh_done_status = stat_r;
   assign bh_done_irq    = stat_r && !bh_done_mask;
   assign list_end       = end_r;
   assign chain_state    = st_r;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   start_fetch_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      (st_r == DLL_IDLE && lf_enable_wr) |=> st_r == DLL_FETCH)
      else $error("enable write did not start the list follower");
   fetch_five_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      (st_r == DLL_FETCH && busy_r && bus_ack && word_r == 3'h4)
      |=> st_r != DLL_FETCH && word_r == `DLL_ENTRY_WORDS)
      else $error("entry fetch did not end after five words");
   lf_lapse_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      (st_r == DLL_FETCH && busy_r && bus_ack && word_r == 3'h4
       && !lf_partner_enable) |=> st_r == DLL_IDLE)
      else $error("list follower did not lapse to disabled");
   partner_on_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      (st_r == DLL_FETCH && busy_r && bus_ack && word_r == 3'h4
       && lf_partner_enable && lf_partner_channel_select == BH_CHANNEL)
      |=> st_r == DLL_BLOCK && xfer_cnt_r == '0)
      else $error("block channel not enabled after fetch");
   done_status_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      blk_done |=> stat_r && xfer_cnt_r == '0)
      else $error("completion status or count clear missing");
   relink_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      (blk_done && bh_cfg_r[`DLL_CFG_PEN_BIT]
       && bh_cfg_r[`DLL_CFG_PSEL_MSB:`DLL_CFG_PSEL_LSB] == LF_CHANNEL)
      |=> st_r == DLL_FETCH ##1 busy_r && addr_r == lf_src_r)
      else $error("list follower not restarted after block");
   single_word_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      (blk_done && bh_len_r == '0) |-> rd_cnt_r == 32'h1)
      else $error("extra read on a one-transfer block");
   chain_stop_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      (blk_done && !bh_cfg_r[`DLL_CFG_PEN_BIT])
      |=> st_r == DLL_IDLE && list_end ##1 !list_end)
      else $error("chain did not stop on last entry");
   pace_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      ($rose(busy_r) && $past(st_r) == DLL_BLOCK)
      |-> $past(periph_ok(src_sel, src_periph_req)))
      else $error("beat issued without peripheral request");
   both_req_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      (issue_rd || issue_wr) && src_sel != 4'h0 && dst_sel != 4'h0
      |-> src_periph_req[src_sel] && dst_periph_req[dst_sel])
      else $error("peripheral pair moved without both requests");
endmodule

`default_nettype wire

// ### dll_consts.svh
/*
 Constants of the linked-list chaining DMA block: entry layout,
 configuration word fields, channel numbers, reset value and FIFO depth.
 Assumes it is included by its bare name, before the package.
*/
`ifndef DLL_CONSTS_SVH
`define DLL_CONSTS_SVH

// Words in one linked-list entry and index of the last one
`define DLL_ENTRY_WORDS   3'h5
`define DLL_ENTRY_LAST    3'h4

// Configuration word fields
`define DLL_CFG_SIZE_LSB  0
`define DLL_CFG_SIZE_MSB  1
`define DLL_CFG_SRC_LSB   4
`define DLL_CFG_SRC_MSB   7
`define DLL_CFG_DST_LSB   8
`define DLL_CFG_DST_MSB   11
`define DLL_CFG_PEN_BIT   12
`define DLL_CFG_PSEL_LSB  13
`define DLL_CFG_PSEL_MSB  17

// Default channel numbers of the pair
`define DLL_BH_CHANNEL    5'h00
`define DLL_LF_CHANNEL    5'h01

// Reset value and default FIFO depth
`define DLL_ZERO_WORD     32'h0000_0000
`define DLL_FIFO_DEPTH    32

`endif

// ### dll_mem_model.sv
/*
 Behavioural system bus slave with a small word memory for the chained DMA.
 Assumes one beat outstanding and a clock shared with the design.
*/
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
module dll_mem_model (
   input  wire logic               core_clk,
   input  wire logic               sys_rst,
   input  wire logic [3:0]         ack_delay,
   input  wire logic               bus_req,
   input  wire logic               bus_write,
   input  wire logic [31:0]        bus_addr,
   input  wire dll_pkg::dll_size_t bus_size,
   input  wire logic [31:0]        bus_wdata,
   output logic                    bus_ack,
   output logic [31:0]             bus_rdata
);
   import dll_pkg::*;
   logic [31:0] mem [0:255];
   logic [3:0]  wait_r;
   logic [31:0] noise_r;
   int          wr_count;
   int          rd_count;
   int          bad_size;

   // Ack after a programmable wait; zero answers in the request's cycle
   assign bus_ack = bus_req && (wait_r == ack_delay);
   // Outside an ack the data lines churn so stale data is never trusted
   assign bus_rdata = bus_ack ? mem[bus_addr[9:2]] : noise_r;

   // Beat bookkeeping; bench preloads mem directly, so plain always
   always @(posedge core_clk) begin
      noise_r <= noise_r + 32'h9E37_79B9;
      if (sys_rst) begin
         wait_r   <= 4'h0;
         wr_count <= 0;
         rd_count <= 0;
         bad_size <= 0;
      end else if (bus_ack) begin
         wait_r <= 4'h0;
         // Every list in the bench moves whole words only
         if (bus_size != DLL_WORD) begin
            bad_size <= bad_size + 1;
         end
         if (bus_write) begin
            mem[bus_addr[9:2]] <= bus_wdata;
            wr_count           <= wr_count + 1;
         end else begin
            rd_count <= rd_count + 1;
         end
      end else if (bus_req) begin
         wait_r <= wait_r + 4'h1;
      end
   end
   initial noise_r = 32'h5A5A_A5A5;
endmodule
`default_nettype wire

// ### dll_pkg.sv
/*
 Types of the linked-list chaining DMA block.
 Assumes dll_consts.svh sits in the same folder.
*/
`include "dll_consts.svh"

package dll_pkg;

   // Sequencer states
   typedef enum logic [1:0] {
      DLL_IDLE  = 2'b00,
      DLL_FETCH = 2'b01,
      DLL_BLOCK = 2'b10
   } dll_state_t;

   // Width of one data beat on the system bus
   typedef enum logic [1:0] {
      DLL_BYTE = 2'b00,
      DLL_HALF = 2'b01,
      DLL_WORD = 2'b10
   } dll_size_t;

endpackage

// ### dll_tb.sv
/*
 Self-checking bench for the chained DMA pair: builds lists in the memory
 model, starts the list follower and checks moved data and status.
 Assumes dll_mem_model and the design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(act, exp, msg) begin comparisons++; if ((act) !== (exp)) begin \
   bad_count++; $display("CHECK FAILED at %0t: %s", $time, msg); end end

////////////////////////////////////////////////////////////////////////////
module tb_top;
   import dll_pkg::*;
   logic             core_clk;
   logic             sys_rst;
   logic             lf_enable_wr;
   logic [31:0]      lf_first_entry;
   logic             lf_pen;
   // Software interrupt register; the model decodes only address bits 9:2,
   // so a write here lands in word 4 of the memory
   localparam logic [31:0] sw_irq_addr = 32'h8010_3C10;
   logic             bh_done_clr;
   logic             bh_done_mask;
   logic             bh_done_status;
   logic             bh_done_irq;
   logic             list_end;
   dll_state_t       chain_state;
   logic [15:0]      src_periph_req;
   logic [15:0]      dst_periph_req;
   logic             bus_req;
   logic             bus_write;
   logic [31:0]      bus_addr;
   dll_size_t        bus_size;
   logic [31:0]      bus_wdata;
   logic             bus_ack;
   logic [31:0]      bus_rdata;
   logic [3:0]       ack_delay;
   int               bad_count;
   int               comparisons;
   int               wr0;
   int               rd0;

   dll_chain dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
      .lf_enable_wr(lf_enable_wr), .lf_first_entry(lf_first_entry),
      .lf_partner_enable(lf_pen), .lf_partner_channel_select(5'h00),
      .bh_done_clr(bh_done_clr), .bh_done_mask(bh_done_mask),
      .bh_done_status(bh_done_status), .bh_done_irq(bh_done_irq),
      .list_end(list_end), .chain_state(chain_state),
      .src_periph_req(src_periph_req), .dst_periph_req(dst_periph_req),
      .bus_req(bus_req), .bus_write(bus_write), .bus_addr(bus_addr),
      .bus_size(bus_size), .bus_wdata(bus_wdata), .bus_ack(bus_ack),
      .bus_rdata(bus_rdata));

   dll_mem_model mem_u (.core_clk(core_clk), .sys_rst(sys_rst),
      .ack_delay(ack_delay), .bus_req(bus_req), .bus_write(bus_write),
      .bus_addr(bus_addr), .bus_size(bus_size), .bus_wdata(bus_wdata),
      .bus_ack(bus_ack), .bus_rdata(bus_rdata));

   // Free-running 50 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // Every input moves a fixed 2 ns after the rising edge
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge core_clk);
         #2;
      end
   endtask

   // Configuration word: size, peripheral selects, partner bits
   function automatic logic [31:0] cfg(input logic [1:0] sz,
         input logic [3:0] s, input logic [3:0] d, input logic pen,
         input logic [4:0] psel);
      logic [31:0] w;
      w = 32'h0;
      w[`DLL_CFG_SIZE_MSB:`DLL_CFG_SIZE_LSB] = sz;
      w[`DLL_CFG_SRC_MSB:`DLL_CFG_SRC_LSB]   = s;
      w[`DLL_CFG_DST_MSB:`DLL_CFG_DST_LSB]   = d;
      w[`DLL_CFG_PEN_BIT]                    = pen;
      w[`DLL_CFG_PSEL_MSB:`DLL_CFG_PSEL_LSB] = psel;
      return w;
   endfunction

   // Lays one five-word entry at a byte address
   task automatic put_entry(input logic [31:0] a, input logic [31:0] s,
         input logic [31:0] d, input logic [31:0] n, input logic [31:0] c,
         input logic [31:0] nx);
      mem_u.mem[a[9:2]]     = s;
      mem_u.mem[a[9:2] + 1] = d;
      mem_u.mem[a[9:2] + 2] = n;
      mem_u.mem[a[9:2] + 3] = c;
      mem_u.mem[a[9:2] + 4] = nx;
   endtask

   // Starts the list follower and waits a bounded time for the list end
   task automatic run_list(input logic [31:0] entry, input int limit);
      int i;
      wr0 = mem_u.wr_count;
      rd0 = mem_u.rd_count;
      lf_first_entry = entry;
      lf_enable_wr   = 1'b1;
      tick(1);
      lf_enable_wr = 1'b0;
      for (i = 0; i < limit && list_end !== 1'b1; i++)
         tick(1);
      `CHK(list_end, 1'b1, "list did not end")
   endtask

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Watchdog sized well past the longest expected run
   initial begin
      #(20 * 20000);
      bad_count++;
      finish_test();
   end

   // Main sequence
   initial begin
      sys_rst = 1'b1;
      lf_enable_wr = 1'b0;
      lf_first_entry = 32'h0;
      lf_pen = 1'b1;
      bh_done_clr = 1'b0;
      bh_done_mask = 1'b1;
      src_periph_req = 16'h0;
      dst_periph_req = 16'h0;
      ack_delay = 4'h0;
      bad_count = 0;
      comparisons = 0;
      for (int k = 0; k < 256; k++)
         mem_u.mem[k] = 32'hDEAD_0000 | k;
      tick(5);
      sys_rst = 1'b0;
      `CHK(chain_state, DLL_IDLE, "state after reset")
      `CHK(bus_req, 1'b0, "bus request after reset")
      `CHK(bh_done_status, 1'b0, "status after reset")
      $display("test reset done");

      // Block of three words, then a last entry; completion masked
      put_entry(32'h000, 32'h100, 32'h200, 32'h2,
         cfg(DLL_WORD, 4'h0, 4'h0, 1'b1, 5'h01), 32'h020);
      put_entry(32'h020, 32'h140, sw_irq_addr, 32'h0,
         cfg(DLL_WORD, 4'h0, 4'h0, 1'b0, 5'h00), 32'h0);
      for (int k = 0; k < 3; k++)
         mem_u.mem[8'h40 + k] = 32'hC0DE_1000 + k;
      mem_u.mem[8'h50] = 32'h0BAD_F00D;
      run_list(32'h000, 400);
      for (int k = 0; k < 3; k++)
         `CHK(mem_u.mem[8'h80 + k], 32'hC0DE_1000 + k, "block word")
      `CHK(mem_u.mem[8'h83], 32'hDEAD_0083, "write past block")
      `CHK(mem_u.mem[8'h04], 32'h0BAD_F00D, "last entry word")
      `CHK(mem_u.wr_count - wr0, 4, "write beat count")
      `CHK(mem_u.rd_count - rd0, 14, "read beat count")
      `CHK(bh_done_status, 1'b1, "completion status")
      `CHK(bh_done_irq, 1'b0, "masked completion")
      tick(1);
      `CHK(chain_state, DLL_IDLE, "chain stopped")
      `CHK(list_end, 1'b0, "list end one cycle")
      $display("test two_entries done");

      // Clear status, unmask, slow bus, lone last entry
      bh_done_clr = 1'b1;
      tick(1);
      bh_done_clr = 1'b0;
      tick(1);
      `CHK(bh_done_status, 1'b0, "status cleared")
      bh_done_mask = 1'b0;
      ack_delay = 4'h2;
      run_list(32'h020, 400);
      `CHK(mem_u.wr_count - wr0, 1, "single word move")
      `CHK(bh_done_irq, 1'b1, "unmasked completion")
      $display("test last_entry done");

      // Peripheral source paces the block; source address fixed
      bh_done_mask = 1'b1;
      ack_delay = 4'h1;
      put_entry(32'h060, 32'h180, 32'h280, 32'h1,
         cfg(DLL_WORD, 4'h2, 4'h0, 1'b0, 5'h00), 32'h0);
      mem_u.mem[8'h60] = 32'h1234_5678;
      fork
         run_list(32'h060, 400);
         begin
            tick(60);
            `CHK(mem_u.wr_count, wr0, "moved without request")
            `CHK(chain_state, DLL_BLOCK, "waiting for request")
            src_periph_req = 16'h0004;
         end
      join
      `CHK(mem_u.mem[8'hA0], 32'h1234_5678, "peripheral word 0")
      `CHK(mem_u.mem[8'hA1], 32'h1234_5678, "peripheral word 1")
      src_periph_req = 16'h0;
      $display("test periph_source done");

      // Peripheral to peripheral needs both requests at once
      put_entry(32'h0C0, 32'h1C0, 32'h2C0, 32'h0,
         cfg(DLL_WORD, 4'h3, 4'h4, 1'b0, 5'h00), 32'h0);
      src_periph_req = 16'h0008;
      fork
         run_list(32'h0C0, 400);
         begin
            tick(60);
            `CHK(mem_u.rd_count - rd0, 5, "read with one request")
            `CHK(mem_u.wr_count, wr0, "write with one request")
            dst_periph_req = 16'h0010;
         end
      join
      `CHK(mem_u.wr_count - wr0, 1, "pair transfer")
      $display("test periph_pair done");

      // Partner enable low: the follower fetches one entry, then lapses
      lf_pen = 1'b0;
      bh_done_clr = 1'b1;
      bh_done_mask = 1'b0;
      wr0 = mem_u.wr_count;
      rd0 = mem_u.rd_count;
      lf_enable_wr = 1'b1;
      tick(1);
      bh_done_clr = 1'b0;
      lf_enable_wr = 1'b0;
      tick(40);
      `CHK(mem_u.rd_count - rd0, 5, "lapsed fetch reads")
      `CHK(chain_state, DLL_IDLE, "follower lapsed")
      `CHK(mem_u.wr_count - wr0, 0, "block ran unenabled")
      `CHK(bh_done_irq, 1'b0, "follower raised interrupt")
      `CHK(mem_u.bad_size, 0, "beat size not word")
      $display("test lapse done");
      finish_test();
   end
endmodule
`default_nettype wire
